// ==== hdl/event_edge_detect.sv ====
`timescale 1ns/10ps
`default_nettype none
module event_edge_detect #(
  parameter int WIDTH = 5
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] source,
  input  wire logic [WIDTH-1:0] riseEnable,
  input  wire logic [WIDTH-1:0] fallEnable,
  output logic      [WIDTH-1:0] eventHit
);

  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;

  // ---------------------------------------------------------------------------
  // Per-source edge qualification
  // ---------------------------------------------------------------------------
  // The reference sample is loaded with the live value on reset, so a source
  // that is already high at reset release raises no false event.
  always_comb begin
    prev_d = source;
  end

  always_ff @(posedge mclk) begin
    prev_q <= prev_d;
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_edge
      assign eventHit[i] = rst_n &&
                           ((riseEnable[i] && source[i] && !prev_q[i]) ||
                            (fallEnable[i] && !source[i] && prev_q[i]));
    end
  endgenerate

endmodule : event_edge_detect
`default_nettype wire

// ==== hdl/otg_event_pkg.sv ====
package otg_event_pkg;

  // ---------------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------------
  localparam logic [5:0] OTG_CONTROL_ADDR       = 6'h0A;
  localparam logic [5:0] RISE_EVENT_ENABLE_ADDR = 6'h0D;
  localparam logic [5:0] FALL_EVENT_ENABLE_ADDR = 6'h10;
  localparam logic [5:0] EVENT_SOURCE_STATUS_ADDR = 6'h13;
  localparam logic [5:0] EVENT_LATCH_ADDR       = 6'h14;
  localparam logic [5:0] LINE_STATE_DEBUG_ADDR  = 6'h15;
  localparam logic [5:0] SET_OFFSET             = 6'h01;
  localparam logic [5:0] CLEAR_OFFSET           = 6'h02;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OTG_CONTROL_RESET      = 8'h06;
  localparam logic [7:0] EVENT_ENABLE_RESET     = 8'h1F;
  localparam logic [7:0] EVENT_LATCH_RESET      = 8'h00;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int EXT_SUPPLY_INDICATOR_SEL_BIT = 7;
  localparam int EXT_SUPPLY_DRIVE_BIT         = 6;
  localparam int SUPPLY_CHARGE_BIT            = 4;
  localparam int SUPPLY_DISCHARGE_BIT         = 3;
  localparam int MINUS_LINE_PULLDOWN_BIT      = 2;
  localparam int PLUS_LINE_PULLDOWN_BIT       = 1;
  localparam int ID_LINE_PULLUP_ENABLE_BIT    = 0;
  localparam int EVENT_SOURCES                = 5;
  localparam logic [7:0] OTG_CONTROL_MASK     = 8'hDF;
  localparam logic [7:0] EVENT_FIELD_MASK     = 8'h1F;

  // ---------------------------------------------------------------------------
  // Register access kinds
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_NONE  = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_SET   = 2'b10,
    ACC_CLEAR = 2'b11
  } access_e;

endpackage : otg_event_pkg

// ==== hdl/rw_set_clear_reg.sv ====
`timescale 1ns/10ps
`default_nettype none
module rw_set_clear_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] BIT_MASK    = 8'hFF
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire otg_event_pkg::access_e    access,
  input  wire logic [7:0]                wrData,
  output logic      [7:0]                value
);

  logic [7:0] value_q;
  logic [7:0] value_d;

  // ---------------------------------------------------------------------------
  // Write, set and clear
  // ---------------------------------------------------------------------------
  always_comb begin
    value_d = value_q;
    unique case (access)
      otg_event_pkg::ACC_NONE:  value_d = value_q;
      otg_event_pkg::ACC_WRITE: value_d = wrData & BIT_MASK;
      otg_event_pkg::ACC_SET:   value_d = (value_q | wrData) & BIT_MASK;
      otg_event_pkg::ACC_CLEAR: value_d = value_q & ~wrData;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;

endmodule : rw_set_clear_reg
`default_nettype wire

// ==== hdl/ulpi_otg_event_registers.sv ====
`timescale 1ns/10ps
`default_nettype none
module ulpi_otg_event_registers #(
  parameter int SOURCES = 5
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [5:0]        regAddr,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [7:0]        regWrData,
  output logic      [7:0]        regRdData,
  input  wire logic              idGroundedRaw,
  input  wire logic              sessionEndCmp,
  input  wire logic              session_valid_cmp,
  input  wire logic              supply_valid_cmp,
  input  wire logic              faultIndicatorIn,
  input  wire logic              host_disconnect_det,
  input  wire logic [1:0]        bus_line_state,
  input  wire logic              lowPowerEnter,
  input  wire logic              serialModeEnter,
  output logic                   power_switch_n,
  output logic                   supply_charge,
  output logic                   supply_discharge,
  output logic                   minus_line_pulldown,
  output logic                   plus_line_pulldown,
  output logic                   id_line_pullup_enable,
  output logic                   rxcmdRequest,
  output logic [SOURCES-1:0]     rxcmdSources
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  otg_event_pkg::access_e otgAccess;
  otg_event_pkg::access_e riseAccess;
  otg_event_pkg::access_e fallAccess;

  function automatic otg_event_pkg::access_e decode_access(
    input logic [5:0] addr,
    input logic [5:0] base,
    input logic       wr
  );
    otg_event_pkg::access_e kind;
    kind = otg_event_pkg::ACC_NONE;
    if (wr && addr == base) begin
      kind = otg_event_pkg::ACC_WRITE;
    end else if (wr && addr == base + otg_event_pkg::SET_OFFSET) begin
      kind = otg_event_pkg::ACC_SET;
    end else if (wr && addr == base + otg_event_pkg::CLEAR_OFFSET) begin
      kind = otg_event_pkg::ACC_CLEAR;
    end
    return kind;
  endfunction : decode_access

  always_comb begin
    otgAccess  = decode_access(regAddr, otg_event_pkg::OTG_CONTROL_ADDR, regWrite);
    riseAccess = decode_access(regAddr, otg_event_pkg::RISE_EVENT_ENABLE_ADDR, regWrite);
    fallAccess = decode_access(regAddr, otg_event_pkg::FALL_EVENT_ENABLE_ADDR, regWrite);
  end

  // ---------------------------------------------------------------------------
  // Control and enable registers
  // ---------------------------------------------------------------------------
  logic [7:0] otgControl;
  logic [7:0] riseEnable;
  logic [7:0] fallEnable;

  rw_set_clear_reg #(
    .RESET_VALUE (otg_event_pkg::OTG_CONTROL_RESET),
    .BIT_MASK    (otg_event_pkg::OTG_CONTROL_MASK)
  ) u_otg_control (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .access (otgAccess),
    .wrData (regWrData),
    .value  (otgControl)
  );

  rw_set_clear_reg #(
    .RESET_VALUE (otg_event_pkg::EVENT_ENABLE_RESET),
    .BIT_MASK    (otg_event_pkg::EVENT_FIELD_MASK)
  ) u_rise_event_enable (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .access (riseAccess),
    .wrData (regWrData),
    .value  (riseEnable)
  );

  rw_set_clear_reg #(
    .RESET_VALUE (otg_event_pkg::EVENT_ENABLE_RESET),
    .BIT_MASK    (otg_event_pkg::EVENT_FIELD_MASK)
  ) u_fall_event_enable (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .access (fallAccess),
    .wrData (regWrData),
    .value  (fallEnable)
  );

  // ---------------------------------------------------------------------------
  // Analog control outputs
  // ---------------------------------------------------------------------------
  // The pins follow the register directly; the link owns the charge and
  // discharge sequencing, so no interlock between the two is added here.
  always_comb begin
    power_switch_n        = !otgControl[otg_event_pkg::EXT_SUPPLY_DRIVE_BIT];
    supply_charge         = otgControl[otg_event_pkg::SUPPLY_CHARGE_BIT];
    supply_discharge      = otgControl[otg_event_pkg::SUPPLY_DISCHARGE_BIT];
    minus_line_pulldown   = otgControl[otg_event_pkg::MINUS_LINE_PULLDOWN_BIT];
    plus_line_pulldown    = otgControl[otg_event_pkg::PLUS_LINE_PULLDOWN_BIT];
    id_line_pullup_enable = otgControl[otg_event_pkg::ID_LINE_PULLUP_ENABLE_BIT];
  end

  // ---------------------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------------------
  logic               idSample_q;
  logic               idSample_d;
  logic [SOURCES-1:0] sourceNow;

  // With sampling off the last ID level is held, so the weak pull-up alone
  // produces no events until the link enables the sampler.
  always_comb begin
    idSample_d = otgControl[otg_event_pkg::ID_LINE_PULLUP_ENABLE_BIT] ? idGroundedRaw : idSample_q;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idSample_q <= 1'b0;
    end else begin
      idSample_q <= idSample_d;
    end
  end

  always_comb begin
    sourceNow[4] = idSample_q;
    sourceNow[3] = sessionEndCmp;
    sourceNow[2] = session_valid_cmp;
    sourceNow[1] = otgControl[otg_event_pkg::EXT_SUPPLY_INDICATOR_SEL_BIT] ?
                   faultIndicatorIn : supply_valid_cmp;
    sourceNow[0] = host_disconnect_det;
  end

  logic [SOURCES-1:0] eventHit;

  event_edge_detect #(
    .WIDTH (SOURCES)
  ) u_edges (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .source     (sourceNow),
    .riseEnable (riseEnable[SOURCES-1:0]),
    .fallEnable (fallEnable[SOURCES-1:0]),
    .eventHit   (eventHit)
  );

  // ---------------------------------------------------------------------------
  // Event latch
  // ---------------------------------------------------------------------------
  logic [SOURCES-1:0] latch_q;
  logic [SOURCES-1:0] latch_d;
  logic               latchRead;

  // A new event in the clearing cycle survives: the set is applied last, so a
  // change that lands on the read edge is reported by the next read instead.
  always_comb begin
    latchRead = regRead && regAddr == otg_event_pkg::EVENT_LATCH_ADDR;
    latch_d   = latch_q;
    if (latchRead || lowPowerEnter || serialModeEnter) begin
      latch_d = '0;
    end
    latch_d = latch_d | eventHit;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      latch_q <= otg_event_pkg::EVENT_LATCH_RESET[SOURCES-1:0];
    end else begin
      latch_q <= latch_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Change report
  // ---------------------------------------------------------------------------
  logic               rxcmd_q;
  logic               rxcmd_d;
  logic [SOURCES-1:0] rxSrc_q;
  logic [SOURCES-1:0] rxSrc_d;

  // The source vector is registered every cycle, so the byte that goes with a
  // request always shows the levels that caused it.
  always_comb begin
    rxcmd_d = |eventHit;
    rxSrc_d = sourceNow;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rxcmd_q <= 1'b0;
      rxSrc_q <= '0;
    end else begin
      rxcmd_q <= rxcmd_d;
      rxSrc_q <= rxSrc_d;
    end
  end

  assign rxcmdRequest = rxcmd_q;
  assign rxcmdSources = rxSrc_q;

  // ---------------------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------------------
  // Each read-write register answers at all three of its addresses, so a read
  // through the set or clear alias returns the same byte as the base.
  logic otgReadHit;
  logic riseReadHit;
  logic fallReadHit;
  logic statusReadHit;
  logic latchReadHit;
  logic debugReadHit;

  always_comb begin
    otgReadHit    = regAddr >= otg_event_pkg::OTG_CONTROL_ADDR &&
                    regAddr <= otg_event_pkg::OTG_CONTROL_ADDR + otg_event_pkg::CLEAR_OFFSET;
    riseReadHit   = regAddr >= otg_event_pkg::RISE_EVENT_ENABLE_ADDR &&
                    regAddr <= otg_event_pkg::RISE_EVENT_ENABLE_ADDR + otg_event_pkg::CLEAR_OFFSET;
    fallReadHit   = regAddr >= otg_event_pkg::FALL_EVENT_ENABLE_ADDR &&
                    regAddr <= otg_event_pkg::FALL_EVENT_ENABLE_ADDR + otg_event_pkg::CLEAR_OFFSET;
    statusReadHit = regAddr == otg_event_pkg::EVENT_SOURCE_STATUS_ADDR;
    latchReadHit  = regAddr == otg_event_pkg::EVENT_LATCH_ADDR;
    debugReadHit  = regAddr == otg_event_pkg::LINE_STATE_DEBUG_ADDR;
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  logic [7:0] statusByte;
  logic [7:0] latchByte;
  logic [7:0] debugByte;
  logic [7:0] rd_q;
  logic [7:0] rd_d;

  // Reserved bits are built as zero here rather than by concatenation, so the
  // read byte stays correct if the source count parameter is changed.
  always_comb begin
    statusByte              = 8'h00;
    latchByte               = 8'h00;
    debugByte               = 8'h00;
    statusByte[SOURCES-1:0] = sourceNow;
    latchByte[SOURCES-1:0]  = latch_q;
    debugByte[1:0]          = bus_line_state;
  end

  always_comb begin
    rd_d = 8'h00;
    if (regRead) begin
      if (otgReadHit) begin
        rd_d = otgControl;
      end else if (riseReadHit) begin
        rd_d = riseEnable;
      end else if (fallReadHit) begin
        rd_d = fallEnable;
      end else if (statusReadHit) begin
        rd_d = statusByte;
      end else if (latchReadHit) begin
        rd_d = latchByte;
      end else if (debugReadHit) begin
        rd_d = debugByte;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign regRdData = rd_q;

endmodule : ulpi_otg_event_registers
`default_nettype wire

// ==== tb/link_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module link_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       rxcmdRequest,
  input  wire logic [4:0] rxcmdSources,
  output logic      [7:0] eventCount,
  output logic      [4:0] lastSources
);
  // ---------------------------------------------------------------------------
  // Event intake
  // ---------------------------------------------------------------------------
  // The link relies on RXCMD updates alone, so a count is kept instead of latch polling.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      eventCount  <= 8'h00;
      lastSources <= 5'h00;
    end else if (rxcmdRequest) begin
      eventCount  <= eventCount + 8'h01;
      lastSources <= rxcmdSources;
    end
  end
endmodule : link_model
`default_nettype wire

// ==== tb/test_ulpi_otg_event_registers.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_ulpi_otg_event_registers;
  // ---------------------------------------------------------------------------
  // Bench
  // ---------------------------------------------------------------------------
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic [5:0] regAddr = 6'h00;
  logic [7:0] regWrData = 8'h00;
  logic [4:0] srcIn = 5'h00;
  logic       fault = 1'b0;
  logic [1:0] lineSt = 2'b00;
  logic [1:0] modeIn = 2'b00;
  logic [7:0] regRdData;
  logic [5:0] ctlOut;
  logic       rxcmdRequest;
  logic [4:0] rxcmdSources;
  logic [4:0] lastSrc;
  logic [7:0] evCnt;
  logic [5:0] rAddr [4] = '{6'h0A, 6'h0D, 6'h10, 6'h14};
  logic [7:0] rVal [4] = '{8'h06, 8'h1F, 8'h1F, 8'h00};
  int         num_errors = 0;
  int         check_count = 0;
  int         cycles = 0;
  always #12.5 mclk = ~mclk;
  ulpi_otg_event_registers dut (
    .mclk, .rst_n, .regAddr, .regWrite, .regRead, .regWrData, .regRdData,
    .idGroundedRaw(srcIn[4]), .sessionEndCmp(srcIn[3]), .session_valid_cmp(srcIn[2]),
    .supply_valid_cmp(srcIn[1]), .faultIndicatorIn(fault), .host_disconnect_det(srcIn[0]),
    .bus_line_state(lineSt), .lowPowerEnter(modeIn[0]), .serialModeEnter(modeIn[1]),
    .power_switch_n(ctlOut[5]), .supply_charge(ctlOut[4]), .supply_discharge(ctlOut[3]),
    .minus_line_pulldown(ctlOut[2]), .plus_line_pulldown(ctlOut[1]), .id_line_pullup_enable(ctlOut[0]),
    .rxcmdRequest, .rxcmdSources);
  link_model lm (.mclk, .rst_n, .rxcmdRequest, .rxcmdSources, .eventCount(evCnt), .lastSources(lastSrc));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [5:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task rd(input logic [5:0] a, input logic [7:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    chk(regRdData, e);
    @(posedge mclk);
  endtask : rd
  task step;
    repeat (3) @(posedge mclk);
  endtask : step
  task complete_run;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // A hung handshake would otherwise run forever; the ceiling is well above the sequence length.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk({2'b00, ctlOut}, 8'h26);
    for (int i = 0; i < 4; i++) rd(rAddr[i], rVal[i]);
    wr(6'h0A, 8'hFF);
    chk({2'b00, ctlOut}, 8'h1F);
    rd(6'h0A, 8'hDF);
    wr(6'h0C, 8'hD8);
    rd(6'h0C, 8'h07);
    chk({2'b00, ctlOut}, 8'h27);
    wr(6'h0B, 8'h40);
    rd(6'h0B, 8'h47);
    chk({2'b00, ctlOut}, 8'h07);
    wr(6'h13, 8'hFF);
    rd(6'h13, 8'h00);
    rd(6'h30, 8'h00);
    lineSt <= 2'b10;
    rd(6'h15, 8'h02);
    for (int i = 0; i < 5; i++) begin
      srcIn[i] <= 1'b1;
      step();
      rd(6'h14, 8'h01 << i);
      chk({3'b000, lastSrc}, 8'h01 << i);
      rd(6'h14, 8'h00);
      srcIn[i] <= 1'b0;
      step();
      rd(6'h14, 8'h01 << i);
    end
    chk(evCnt, 8'h0A);
    wr(6'h0F, 8'h08);
    rd(6'h0D, 8'h17);
    srcIn[3] <= 1'b1;
    step();
    rd(6'h14, 8'h00);
    srcIn[3] <= 1'b0;
    step();
    rd(6'h14, 8'h08);
    wr(6'h10, 8'h00);
    rd(6'h11, 8'h00);
    srcIn[2] <= 1'b1;
    step();
    srcIn[2] <= 1'b0;
    step();
    chk(evCnt, 8'h0C);
    for (int j = 0; j < 2; j++) begin
      srcIn[j] <= 1'b1;
      step();
      modeIn <= 2'b01 << j;
      @(posedge mclk);
      modeIn <= 2'b00;
      rd(6'h14, 8'h00);
    end
    wr(6'h0B, 8'h80);
    rd(6'h13, 8'h01);
    fault <= 1'b1;
    step();
    rd(6'h13, 8'h03);
    wr(6'h0C, 8'h01);
    chk({2'b00, ctlOut}, 8'h06);
    srcIn[4] <= 1'b1;
    step();
    rd(6'h13, 8'h03);
    wr(6'h0B, 8'h01);
    step();
    rd(6'h13, 8'h13);
    wr(6'h0E, 8'hE8);
    rd(6'h0F, 8'h1F);
    // The SE0 hold before charging is shortened to a few cycles; the block does not time it.
    wr(6'h0B, 8'h08);
    chk({2'b00, ctlOut}, 8'h0F);
    srcIn[3] <= 1'b1;
    step();
    chk({3'b000, lastSrc}, 8'h1B);
    wr(6'h0C, 8'h08);
    chk({2'b00, ctlOut}, 8'h07);
    lineSt <= 2'b00;
    rd(6'h15, 8'h00);
    rd(6'h13, 8'h1B);
    wr(6'h0B, 8'h10);
    chk({2'b00, ctlOut}, 8'h17);
    chk(evCnt, 8'h11);
    rd(6'h14, 8'h1A);
    rd(6'h14, 8'h00);
    complete_run();
  end
endmodule : test_ulpi_otg_event_registers
`default_nettype wire

// ==== tb/ulpi_otg_event_registers_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module ulpi_otg_event_registers_checker #(
  parameter int SOURCES = 5
) (
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire logic [5:0]         regAddr,
  input wire logic               regWrite,
  input wire logic               regRead,
  input wire logic [7:0]         regWrData,
  input wire logic [7:0]         regRdData,
  input wire logic               idGroundedRaw,
  input wire logic               sessionEndCmp,
  input wire logic               session_valid_cmp,
  input wire logic               supply_valid_cmp,
  input wire logic               faultIndicatorIn,
  input wire logic               host_disconnect_det,
  input wire logic [1:0]         bus_line_state,
  input wire logic               lowPowerEnter,
  input wire logic               serialModeEnter,
  input wire logic               power_switch_n,
  input wire logic               minus_line_pulldown,
  input wire logic               plus_line_pulldown,
  input wire logic               id_line_pullup_enable,
  input wire logic               rxcmdRequest,
  input wire logic [SOURCES-1:0] rxcmdSources
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [5:0] srcAll;
  assign srcAll = {idGroundedRaw, sessionEndCmp, session_valid_cmp, supply_valid_cmp, faultIndicatorIn,
                   host_disconnect_det};
  property p_rst_val; $rose(rst_n) |-> plus_line_pulldown && minus_line_pulldown && power_switch_n; endproperty
  a_rst_val: assert property (p_rst_val) else $error("control reset value wrong");
  property p_base_wr; regWrite && regAddr == 6'h0A |=> power_switch_n == !$past(regWrData[6]); endproperty
  a_base_wr: assert property (p_base_wr) else $error("switch output does not follow write");
  property p_set_wr; regWrite && regAddr == 6'h0B && regWrData[6] |=> !power_switch_n; endproperty
  a_set_wr: assert property (p_set_wr) else $error("set write did not take");
  property p_clr_wr; regWrite && regAddr == 6'h0C && regWrData[0] |=> !id_line_pullup_enable; endproperty
  a_clr_wr: assert property (p_clr_wr) else $error("clear write did not take");
  property p_idle; !regRead |=> regRdData == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_dbg; regRead && regAddr == 6'h15 |=> regRdData == {6'h00, $past(bus_line_state)}; endproperty
  a_dbg: assert property (p_dbg) else $error("line state read wrong");
  property p_stat;
    regRead && regAddr == 6'h13 |=> regRdData[7:5] == 3'b000 && regRdData[3] == $past(sessionEndCmp)
      && regRdData[2] == $past(session_valid_cmp) && regRdData[0] == $past(host_disconnect_det);
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_src;
    rxcmdRequest |-> rxcmdSources[3] == $past(sessionEndCmp) && rxcmdSources[2] == $past(session_valid_cmp)
      && rxcmdSources[0] == $past(host_disconnect_det);
  endproperty
  a_src: assert property (p_src) else $error("event source vector wrong");
  // The ID sampler adds one stage, so a change or write one cycle further back also explains a request.
  property p_cause;
    rxcmdRequest |-> $past(srcAll) != $past(srcAll, 2) || $past(srcAll, 2) != $past(srcAll, 3)
      || $past(regWrite, 2) || $past(regWrite, 3);
  endproperty
  a_cause: assert property (p_cause) else $error("event without a source change");
  property p_latch_clr;
    (regRead && regAddr == 6'h14 || lowPowerEnter || serialModeEnter) ##1 !rxcmdRequest
      ##1 (regRead && regAddr == 6'h14 && !rxcmdRequest) |=> regRdData == 8'h00;
  endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared");
endmodule : ulpi_otg_event_registers_checker
bind ulpi_otg_event_registers ulpi_otg_event_registers_checker #(.SOURCES(SOURCES)) u_chk (
  .mclk, .rst_n, .regAddr, .regWrite, .regRead, .regWrData, .regRdData, .idGroundedRaw, .sessionEndCmp,
  .session_valid_cmp, .supply_valid_cmp, .faultIndicatorIn, .host_disconnect_det, .bus_line_state,
  .lowPowerEnter, .serialModeEnter, .power_switch_n, .minus_line_pulldown, .plus_line_pulldown,
  .id_line_pullup_enable, .rxcmdRequest, .rxcmdSources);
`default_nettype wire
